// File: rtl/cpi_host.sv
// module: host that initialises and operates three cascaded interrupt controllers
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module cpi_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic io_mem,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  import cpi_pkg::*;

  // ********************************************************
  // declarations
  // ********************************************************
  cpi_cfg_s [2:0] cfg_q;
  cpi_cfg_s [2:0] cfg_d;
  logic [7:0] icr_q;
  logic [7:0] icr_d;
  logic icr_en_q;
  logic icr_en_d;
  logic [23:0] mask_q;
  logic [23:0] mask_d;
  logic [11:0] op_q;
  logic [11:0] op_d;
  cpi_state_e state_q;
  cpi_state_e state_d;
  logic [1:0] ctl_q;
  logic [1:0] ctl_d;
  logic [3:0] step_q;
  logic [3:0] step_d;
  logic [2:0] ready_q;
  logic [2:0] ready_d;
  logic drop_q;
  logic drop_d;
  logic [31:0] rdata_q;

  cpi_io_s [2:0] seq_req;
  logic [2:0] seq_valid;
  logic [2:0] seq_last;
  cpi_io_s io_q;
  cpi_io_s op_req;
  cpi_io_s icr_req;
  cpi_io_s issue_req;
  logic issue;
  logic rd_valid;
  logic [7:0] rd_data;

  // ********************************************************
  // register bus decode
  // ********************************************************
  logic wr_ctrl;
  logic wr_op;
  logic wr_stat;
  logic wr_icr;
  logic wr_mask;
  logic [2:0] wr_cfg;
  logic busy;
  logic start_req;
  logic pcat_req;
  logic op_ok;
  logic [1:0] op_sel;
  logic op_upper;
  logic op_read;
  logic cur_enabled;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  assign busy = (state_q != ST_IDLE);
  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign wr_op = reg_wr && (reg_addr == REG_OP);
  assign wr_stat = reg_wr && (reg_addr == REG_STAT);
  assign wr_icr = reg_wr && (reg_addr == REG_ICR);
  assign wr_mask = reg_wr && (reg_addr == REG_MASK);
  assign wr_cfg[0] = reg_wr && (reg_addr == REG_CFG_M);
  assign wr_cfg[1] = reg_wr && (reg_addr == REG_CFG_S1);
  assign wr_cfg[2] = reg_wr && (reg_addr == REG_CFG_S2);
  assign start_req = wr_ctrl && reg_wdata[CTRL_START_BIT];
  assign pcat_req = wr_ctrl && reg_wdata[CTRL_PCAT_BIT];
  // config is frozen while a sequence runs, so a half-sent stream stays coherent
  assign op_ok = wr_op && !busy && (reg_wdata[9:8] != 2'b11);

  // ********************************************************
  // per-controller word generators
  // ********************************************************
  for (genvar g = 0; g < 3; g++) begin : gen_seq
    cpi_seq_gen #(
      .LO_PORT(LO_PORTS[g]),
      .HI_PORT(HI_PORTS[g]),
      .IS_MASTER(g == 0),
      .ATTACH_ID(ATTACH_IDS[g])
    ) u_seq (
      .cfg(cfg_q[g]),
      .mask(mask_q[8*g +: 8]),
      .step(step_q),
      .req(seq_req[g]),
      .req_valid(seq_valid[g]),
      .last(seq_last[g])
    );
  end

  // ********************************************************
  // single operation: mask access on upper, op words on lower
  // ********************************************************
  assign op_sel = op_q[9:8];
  assign op_upper = op_q[10];
  assign op_read = op_q[11];
  assign op_req = '{wr: !op_read, rd: op_read, mem: 1'b0,
                    addr: (op_upper ? HI_PORTS[op_sel] : LO_PORTS[op_sel]),
                    data: op_q[7:0]};
  // global trigger-mode bits live in the memory-mapped control register
  assign icr_req = '{wr: 1'b1, rd: 1'b0, mem: 1'b1, addr: ICR_ADDR, data: icr_q};
  assign cur_enabled = cfg_q[ctl_q].enable;
  assign issue = ((state_q == ST_INIT) && cur_enabled && seq_valid[ctl_q])
               || (state_q == ST_ICR) || (state_q == ST_OP);
  assign issue_req = (state_q == ST_INIT) ? seq_req[ctl_q] :
                     (state_q == ST_ICR) ? icr_req : op_req;

  // ********************************************************
  // sequencer
  // ********************************************************
  always_comb begin
    state_d = state_q;
    ctl_d = ctl_q;
    step_d = step_q;
    ready_d = ready_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req) begin
          state_d = ST_INIT;
          ctl_d = 2'd0;
          step_d = STEP_ICW1;
          ready_d = 3'b000;
        end else if (op_ok) begin
          state_d = ST_OP;
        end
      end
      ST_INIT: begin
        // skipped controllers and absent words cost one idle cycle each
        if (!cur_enabled || seq_last[ctl_q]) begin
          ready_d[ctl_q] = cur_enabled;
          step_d = STEP_ICW1;
          if (ctl_q == 2'd2) begin
            state_d = icr_en_q ? ST_ICR : ST_IDLE;
          end else begin
            ctl_d = ctl_q + 2'd1;
          end
        end else begin
          step_d = step_q + 4'd1;
        end
      end
      ST_ICR: begin
        state_d = ST_IDLE;
      end
      ST_OP: begin
        state_d = op_read ? ST_OP_WAIT : ST_IDLE;
      end
      ST_OP_WAIT: begin
        if (rd_valid) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ********************************************************
  // software registers
  // ********************************************************
  always_comb begin
    cfg_d = cfg_q;
    icr_d = icr_q;
    icr_en_d = icr_en_q;
    mask_d = mask_q;
    op_d = op_q;
    if (!busy) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_cfg[i]) begin
          cfg_d[i] = cpi_cfg_s'(reg_wdata[15:0]);
        end
      end
      if (wr_icr) begin
        icr_d = reg_wdata[7:0];
      end
      if (wr_mask) begin
        mask_d = reg_wdata[23:0];
      end
      if (wr_ctrl) begin
        icr_en_d = reg_wdata[CTRL_ICR_EN_BIT];
      end
      if (pcat_req) begin
        // cascaded master with slave one, slave two bypassed to input five
        cfg_d[0] = '{enable: 1'b1, slave_two_present: 1'b0, slave_one_present: 1'b1,
                     special_fully_nested: 1'b0, auto_end_of_interrupt: 1'b0,
                     need_four: 1'b1, single_controller_flag: 1'b0, level_trig: 1'b0,
                     vector_base_high: PCAT_M_VEC_HIGH, vector_low_field: 3'b000};
        cfg_d[1] = '{enable: 1'b1, slave_two_present: 1'b0, slave_one_present: 1'b0,
                     special_fully_nested: 1'b0, auto_end_of_interrupt: 1'b0,
                     need_four: 1'b1, single_controller_flag: 1'b0, level_trig: 1'b0,
                     vector_base_high: PCAT_S1_VEC_HIGH, vector_low_field: 3'b000};
        cfg_d[2] = CFG_RESET;
        icr_d = icr_q | (8'h01 << ICR_M_GINT_BIT) | (8'h01 << ICR_S1_GINT_BIT);
        icr_en_d = 1'b1;
      end
      if (op_ok) begin
        op_d = reg_wdata[11:0];
      end
    end
  end

  // sticky refusal flag; a new refusal beats a same-cycle clear
  assign drop_d = ((wr_op || wr_ctrl || (|wr_cfg) || wr_icr || wr_mask) && busy)
                || (wr_op && !busy && (reg_wdata[9:8] == 2'b11))
                || (drop_q && !(wr_stat && reg_wdata[STAT_DROP_BIT]));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      ctl_q <= 2'd0;
      step_q <= STEP_ICW1;
      ready_q <= 3'b000;
      drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctl_q <= ctl_d;
      step_q <= step_d;
      ready_q <= ready_d;
      drop_q <= drop_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= {3{CFG_RESET}};
      icr_q <= ICR_RESET;
      icr_en_q <= 1'b0;
      mask_q <= MASK_RESET;
      op_q <= 12'h000;
    end else begin
      cfg_q <= cfg_d;
      icr_q <= icr_d;
      icr_en_q <= icr_en_d;
      mask_q <= mask_d;
      op_q <= op_d;
    end
  end

  // ********************************************************
  // device port driver
  // ********************************************************
  cpi_io_drv u_drv (
    .clk(clk),
    .sys_rst(sys_rst),
    .issue(issue),
    .req(issue_req),
    .io_rdata(io_rdata),
    .io_q(io_q),
    .rd_valid(rd_valid),
    .rd_data(rd_data)
  );

  assign io_wr = io_q.wr;
  assign io_rd = io_q.rd;
  assign io_mem = io_q.mem;
  assign io_addr = io_q.addr;
  assign io_wdata = io_q.data;

  // ********************************************************
  // read-back, one cycle after the strobe
  // ********************************************************
  assign stat_word = {13'h0000, ready_q, rd_data, 4'h0, 1'b0,
                      drop_q, (ready_q[0] && !busy), busy};
  assign rd_mux = (reg_addr == REG_CTRL) ? {29'h0000_0000, icr_en_q, 2'b00} :
                  (reg_addr == REG_CFG_M) ? {16'h0000, cfg_q[0]} :
                  (reg_addr == REG_CFG_S1) ? {16'h0000, cfg_q[1]} :
                  (reg_addr == REG_CFG_S2) ? {16'h0000, cfg_q[2]} :
                  (reg_addr == REG_OP) ? {20'h0_0000, op_q} :
                  (reg_addr == REG_STAT) ? stat_word :
                  (reg_addr == REG_ICR) ? {24'h00_0000, icr_q} :
                  (reg_addr == REG_MASK) ? {8'h00, mask_q} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : cpi_host

// File: rtl/cpi_pkg.sv
// package: constants and types for the cascaded interrupt controller init host
package cpi_pkg;

  // ********************************************************
  // device port map
  // ********************************************************
  localparam logic [15:0] PORT_M_LO = 16'h0020;
  localparam logic [15:0] PORT_M_HI = 16'h0021;
  localparam logic [15:0] PORT_S1_LO = 16'h00A0;
  localparam logic [15:0] PORT_S1_HI = 16'h00A1;
  localparam logic [15:0] PORT_S2_LO = 16'h0024;
  localparam logic [15:0] PORT_S2_HI = 16'h0025;
  localparam logic [15:0] ICR_ADDR = 16'h0D00;
  localparam logic [2:0][15:0] LO_PORTS = {PORT_S2_LO, PORT_S1_LO, PORT_M_LO};
  localparam logic [2:0][15:0] HI_PORTS = {PORT_S2_HI, PORT_S1_HI, PORT_M_HI};

  // ********************************************************
  // control word encodings
  // ********************************************************
  localparam logic [7:0] ICW1_BASE = 8'h10;
  localparam int ICW1_NEED_FOUR_BIT = 0;
  localparam int ICW1_SINGLE_BIT = 1;
  localparam int ICW1_LEVEL_BIT = 3;
  localparam int ICW3_SLAVE_ONE_BIT = 2;
  localparam int ICW3_SLAVE_TWO_BIT = 5;
  localparam logic [7:0] SLAVE_ONE_ATTACH = 8'h02;
  localparam logic [7:0] SLAVE_TWO_ATTACH = 8'h05;
  localparam logic [2:0][7:0] ATTACH_IDS = {SLAVE_TWO_ATTACH, SLAVE_ONE_ATTACH, 8'h00};
  localparam logic [7:0] ICW4_FIXED = 8'h01;
  localparam int ICW4_AUTO_END_OF_INTERRUPT_BIT = 1;
  localparam int ICW4_SPECIAL_FULLY_NESTED_BIT = 4;
  localparam logic [7:0] OCW2_SPECIFIC_EOI = 8'h60;
  localparam int ICR_M_GINT_BIT = 0;
  localparam int ICR_S1_GINT_BIT = 1;
  localparam logic [4:0] PCAT_M_VEC_HIGH = 5'h01;
  localparam logic [4:0] PCAT_S1_VEC_HIGH = 5'h0E;

  // sequence steps: words, mask, then eight eois
  localparam logic [3:0] STEP_ICW1 = 4'h0;
  localparam logic [3:0] STEP_ICW2 = 4'h1;
  localparam logic [3:0] STEP_ICW3 = 4'h2;
  localparam logic [3:0] STEP_ICW4 = 4'h3;
  localparam logic [3:0] STEP_MASK = 4'h4;
  localparam logic [3:0] STEP_EOI0 = 4'h5;
  localparam logic [3:0] STEP_LAST = 4'hC;

  // ********************************************************
  // host register map
  // ********************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG_M = 8'h04;
  localparam logic [7:0] REG_CFG_S1 = 8'h08;
  localparam logic [7:0] REG_CFG_S2 = 8'h0C;
  localparam logic [7:0] REG_OP = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_ICR = 8'h18;
  localparam logic [7:0] REG_MASK = 8'h1C;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PCAT_BIT = 1;
  localparam int CTRL_ICR_EN_BIT = 2;
  localparam int STAT_DROP_BIT = 2;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0] ICR_RESET = 8'h00;
  localparam logic [23:0] MASK_RESET = 24'hFF_FFFF;

  // ********************************************************
  // types
  // ********************************************************
  typedef struct packed {
    logic enable;
    logic slave_two_present;
    logic slave_one_present;
    logic special_fully_nested;
    logic auto_end_of_interrupt;
    logic need_four;
    logic single_controller_flag;
    logic level_trig;
    logic [4:0] vector_base_high;
    logic [2:0] vector_low_field;
  } cpi_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic mem;
    logic [15:0] addr;
    logic [7:0] data;
  } cpi_io_s;

  typedef enum logic [2:0] {ST_IDLE, ST_INIT, ST_ICR, ST_OP, ST_OP_WAIT} cpi_state_e;

endpackage : cpi_pkg

// File: rtl/cpi_seq_gen.sv
// module: one controller's init word stream, one word per step
`timescale 1ns/1ns
module cpi_seq_gen #(
  parameter logic [15:0] LO_PORT = 16'h0020,
  parameter logic [15:0] HI_PORT = 16'h0021,
  parameter bit IS_MASTER = 1'b1,
  parameter logic [7:0] ATTACH_ID = 8'h00
) (
  input wire cpi_pkg::cpi_cfg_s cfg,
  input wire logic [7:0] mask,
  input wire logic [3:0] step,
  output cpi_pkg::cpi_io_s req,
  output logic req_valid,
  output logic last
);
  import cpi_pkg::*;

  // ********************************************************
  // word images
  // ********************************************************
  logic [7:0] icw1_w;
  logic [7:0] icw2_w;
  logic [7:0] icw3_w;
  logic [7:0] icw4_w;
  logic [7:0] eoi_w;
  logic [3:0] eoi_idx;
  logic upper;
  logic [7:0] data_w;

  // word one: restart plus three latched choices
  assign icw1_w = ICW1_BASE | (8'(cfg.level_trig) << ICW1_LEVEL_BIT)
                | (8'(cfg.single_controller_flag) << ICW1_SINGLE_BIT)
                | (8'(cfg.need_four) << ICW1_NEED_FOUR_BIT);
  assign icw2_w = {cfg.vector_base_high, cfg.vector_low_field};
  // master lists cascaded inputs, slave gives its attach point
  assign icw3_w = IS_MASTER ?
                  ((8'(cfg.slave_one_present) << ICW3_SLAVE_ONE_BIT)
                  | (8'(cfg.slave_two_present) << ICW3_SLAVE_TWO_BIT))
                  : ATTACH_ID;
  assign icw4_w = ICW4_FIXED | (8'(cfg.auto_end_of_interrupt) << ICW4_AUTO_END_OF_INTERRUPT_BIT)
                | (8'(cfg.special_fully_nested) << ICW4_SPECIAL_FULLY_NESTED_BIT);
  assign eoi_idx = step - STEP_EOI0;
  assign eoi_w = OCW2_SPECIFIC_EOI | {5'h00, eoi_idx[2:0]};

  // ********************************************************
  // step decode: skipped words report not valid
  // ********************************************************
  assign req_valid = (step == STEP_ICW3) ? !cfg.single_controller_flag :
                     (step == STEP_ICW4) ? cfg.need_four :
                     (step <= STEP_LAST);
  assign upper = (step != STEP_ICW1) && (step <= STEP_MASK);
  assign data_w = (step == STEP_ICW1) ? icw1_w :
                  (step == STEP_ICW2) ? icw2_w :
                  (step == STEP_ICW3) ? icw3_w :
                  (step == STEP_ICW4) ? icw4_w :
                  (step == STEP_MASK) ? mask : eoi_w;
  assign req = '{wr: 1'b1, rd: 1'b0, mem: 1'b0,
                 addr: (upper ? HI_PORT : LO_PORT), data: data_w};
  assign last = (step == STEP_LAST);

endmodule : cpi_seq_gen

// File: rtl/cpi_io_drv.sv
// module: registered device port cycles and read capture
`timescale 1ns/1ns
module cpi_io_drv (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input wire cpi_pkg::cpi_io_s req,
  input wire logic [7:0] io_rdata,
  output cpi_pkg::cpi_io_s io_q,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  import cpi_pkg::*;

  logic rd_wait_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;

  // each request drives the pins for exactly one cycle; back-to-back requests keep io_wr high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_q <= '0;
    end else begin
      io_q <= issue ? req : '0;
    end
  end

  // device answers the cycle after the strobe; capture then
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_wait_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_wait_q <= io_q.rd;
      rd_valid_q <= rd_wait_q;
      if (rd_wait_q) begin
        rd_data_q <= io_rdata;
      end
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;

endmodule : cpi_io_drv

// File: test/cpi_host_checker.sv
// checker: port properties of the controller init host
`timescale 1ns/1ns
module cpi_host_checker
  import cpi_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_mem,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  // ******************************
  // properties
  // ******************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // lower port of any controller
  wire logic io_lo = (io_addr == PORT_M_LO) || (io_addr == PORT_S1_LO)
                     || (io_addr == PORT_S2_LO);

  // steps of an init stream and of the eoi sweep
  sequence s_word_one;
    io_wr && io_lo && io_wdata[4];
  endsequence
  sequence s_next_up;
    io_wr && (io_addr == $past(io_addr) + 16'h0001);
  endsequence
  sequence s_eoi_first;
    io_wr && io_lo && (io_wdata == OCW2_SPECIFIC_EOI);
  endsequence
  sequence s_eoi_next;
    io_wr && (io_wdata == $past(io_wdata) + 8'h01);
  endsequence

  property p_word_pair;
    s_word_one |=> s_next_up;
  endproperty
  a_word_pair: assert property (p_word_pair) else $error("upper word missing");
  property p_s1_attach;
    io_wr && (io_addr == PORT_S1_LO) && io_wdata[4] && !io_wdata[ICW1_SINGLE_BIT]
      |-> ##2 io_wr && (io_addr == PORT_S1_HI) && (io_wdata == SLAVE_ONE_ATTACH);
  endproperty
  a_s1_attach: assert property (p_s1_attach) else $error("slave one attach");
  property p_eoi_run;
    s_eoi_first |=> s_eoi_next [*7];
  endproperty
  a_eoi_run: assert property (p_eoi_run) else $error("eoi sweep broken");
  property p_io_idle;
    !(io_wr || io_rd) |-> (io_addr == 16'h0000) && (io_wdata == 8'h00) && !io_mem;
  endproperty
  a_io_idle: assert property (p_io_idle) else $error("idle bus not zero");
  property p_io_excl;
    !(io_wr && io_rd);
  endproperty
  a_io_excl: assert property (p_io_excl) else $error("both strobes");
  property p_mem_icr;
    io_mem |-> io_wr && (io_addr == ICR_ADDR);
  endproperty
  a_mem_icr: assert property (p_mem_icr) else $error("memory cycle off target");
  property p_rd_window;
    !$past(reg_rd) |-> (reg_rdata == 32'h0000_0000);
  endproperty
  a_rd_window: assert property (p_rd_window) else $error("read data outside window");
  property p_rst_quiet;
    $past(sys_rst) |-> !io_wr && !io_rd && (reg_rdata == 32'h0000_0000);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs after reset");
  property p_rd_single;
    io_rd |=> !io_rd;
  endproperty
  a_rd_single: assert property (p_rd_single) else $error("read strobe too long");
endmodule : cpi_host_checker

bind cpi_host cpi_host_checker u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .io_wr(io_wr), .io_rd(io_rd), .io_mem(io_mem), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_rdata(io_rdata));

// File: test/cpi_dev_model.sv
// device model: three cascaded controllers behind their port pairs
`timescale 1ns/1ns
module cpi_dev_model
  import cpi_pkg::*;
(
  input wire logic clk,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_mem,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  // ******************************
  // port registers
  // ******************************
  // no reset input: contents survive a system reset
  logic [2:0][7:0] iw1 = '0;
  logic [2:0][7:0] vec = '0;
  logic [2:0][7:0] iw3 = '0;
  logic [2:0][7:0] iw4 = '0;
  logic [2:0][7:0] mask = '1;
  logic [2:0][7:0] op_two = '0;
  logic [2:0][7:0] op_three = '0;
  logic [2:0][7:0] nwords = '0;
  logic [2:0][7:0] eoi_cnt = '0;
  logic [2:0][1:0] step = '0;
  logic [2:0] done = 3'h0;
  logic [7:0] icr = 8'h00;
  logic [7:0] rd_q = 8'h00;

  // controller select and next init step
  wire logic [1:0] sel = (io_addr[15:1] == PORT_S1_LO[15:1]) ? 2'h1 :
                         (io_addr[15:1] == PORT_S2_LO[15:1]) ? 2'h2 : 2'h0;
  wire logic [15:0] base = LO_PORTS[sel];
  wire logic hit = io_wr && !io_mem && (io_addr[15:1] == base[15:1]);
  wire logic [1:0] cur = step[sel];
  wire logic [1:0] nstep = (cur == 2'h1 && !iw1[sel][ICW1_SINGLE_BIT]) ? 2'h2 :
                           (cur != 2'h3 && iw1[sel][ICW1_NEED_FOUR_BIT]) ? 2'h3 : 2'h0;
  assign io_rdata = rd_q;
  // bypassed slave: only its top input reaches master input 2/5
  wire logic [1:0] bypass = ~{iw3[0][ICW3_SLAVE_TWO_BIT], iw3[0][ICW3_SLAVE_ONE_BIT]};

  // port decode; a released data line toggles so a stale byte never passes
  always @(posedge clk) begin
    if (io_rd) begin
      rd_q <= io_addr[0] ? mask[sel] : 8'h00;
    end else begin
      rd_q <= ~rd_q;
    end
    if (io_wr && io_mem && (io_addr == ICR_ADDR)) begin
      icr <= io_wdata;
    end
    if (hit && !io_addr[0] && io_wdata[4]) begin
      iw1[sel] <= io_wdata;
      step[sel] <= 2'h1;
      done[sel] <= 1'b0;
      nwords[sel] <= 8'h01;
    end else if (hit && io_addr[0] && (cur == 2'h0)) begin
      mask[sel] <= io_wdata;
    end else if (hit && io_addr[0]) begin
      nwords[sel] <= nwords[sel] + 8'h01;
      step[sel] <= nstep;
      done[sel] <= (nstep == 2'h0);
      if (cur == 2'h1) vec[sel] <= io_wdata;
      if (cur == 2'h2) iw3[sel] <= io_wdata;
      if (cur == 2'h3) iw4[sel] <= io_wdata;
    end else if (hit && done[sel]) begin
      if (io_wdata[3]) op_three[sel] <= io_wdata;
      else op_two[sel] <= io_wdata;
      if (io_wdata[7:3] == 5'h0C) eoi_cnt[sel] <= eoi_cnt[sel] + 8'h01;
    end
  end
endmodule : cpi_dev_model

// File: test/cpi_host_tb_top.sv
// testbench: register-level tests of the init host against the device model
`timescale 1ns/1ns
module cpi_host_tb_top;
  import cpi_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic io_wr, io_rd, io_mem;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  int n_errors = 0;
  int tests_run = 0;

  always #2 clk = ~clk;

  cpi_host uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_mem(io_mem), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));
  cpi_dev_model m (.clk(clk), .io_wr(io_wr), .io_rd(io_rd), .io_mem(io_mem),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  // ******************************
  // access and compare tasks
  // ******************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check(what, {24'h00_0000, seen}, {24'h00_0000, exp});
  endtask : chk8
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // data stand only in the cycle after the strobe edge
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    logic [31:0] d;
    reg_read(a, d);
    check($sformatf("reg_%h", a), d & msk, e);
  endtask : expect_reg
  // bounded poll of the busy bit
  task automatic wait_idle;
    logic [31:0] s;
    for (int i = 0; i < 100; i++) begin
      reg_read(REG_STAT, s);
      if (s[0] === 1'b0) return;
    end
    n_errors++;
    $display("ERROR busy expected 0 seen 1");
    give_verdict();
  endtask : wait_idle
  task automatic op_cycle(input logic [31:0] d);
    reg_write(REG_OP, d);
    wait_idle();
  endtask : op_cycle
  task automatic check_defaults;
    expect_reg(REG_CFG_M, 32'hFFFF_FFFF, {16'h0000, CFG_RESET});
    expect_reg(REG_CFG_S2, 32'hFFFF_FFFF, {16'h0000, CFG_RESET});
    expect_reg(REG_ICR, 32'hFFFF_FFFF, {24'h00_0000, ICR_RESET});
    expect_reg(REG_MASK, 32'hFFFF_FFFF, {8'h00, MASK_RESET});
    expect_reg(REG_STAT, 32'h0000_0007, 32'h0000_0000);
    expect_reg(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : check_defaults

  // ******************************
  // test sequence
  // ******************************
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    check_defaults();
    $display("test defaults done");
    // preset first, then start in a separate write with the icr enable bit set
    reg_write(REG_CTRL, 32'h0000_0002);
    reg_write(REG_CTRL, 32'h0000_0005);
    wait_idle();
    chk8("m_single", m.iw1[0] & 8'h02, 8'h00);
    chk8("m_vec", m.vec[0], 8'h08);
    chk8("s1_vec", m.vec[1], 8'h70);
    chk8("m_cascade", m.iw3[0], 8'h04);
    chk8("bypass", {6'h00, m.bypass}, 8'h02);
    chk8("s1_attach", m.iw3[1], 8'h02);
    chk8("m_w4", m.iw4[0] & 8'h13, ICW4_FIXED);
    chk8("s1_w4", m.iw4[1] & 8'h13, ICW4_FIXED);
    chk8("icr", m.icr & 8'h03, 8'h03);
    chk8("m_eoi", m.eoi_cnt[0], 8'h08);
    chk8("s1_eoi", m.eoi_cnt[1], 8'h08);
    chk8("m_mask", m.mask[0], 8'hFF);
    expect_reg(REG_STAT, 32'h0007_0000, 32'h0003_0000);
    $display("test preset done");
    // second slave only on master, first slave single, word four on second
    reg_write(REG_MASK, 32'h0000_5AC3);
    reg_write(REG_CFG_M, 32'h0000_C028);
    reg_write(REG_CFG_S1, 32'h0000_8248);
    reg_write(REG_CFG_S2, 32'h0000_8D50);
    reg_write(REG_CTRL, 32'h0000_0001);
    wait_idle();
    chk8("m_words", m.nwords[0], 8'h03);
    chk8("s1_words", m.nwords[1], 8'h02);
    chk8("s2_words", m.nwords[2], 8'h04);
    chk8("m_w1", m.iw1[0], 8'h10);
    chk8("s1_w1", m.iw1[1], 8'h12);
    chk8("s2_w1", m.iw1[2], 8'h19);
    chk8("m_cascade", m.iw3[0], 8'h20);
    chk8("s2_attach", m.iw3[2], 8'h05);
    chk8("s2_w4", m.iw4[2], 8'h03);
    chk8("s2_vec", m.vec[2], 8'h50);
    chk8("s1_mask", m.mask[1], 8'h5A);
    chk8("s2_mask", m.mask[2], 8'h00);
    chk8("m_eoi", m.eoi_cnt[0], 8'h10);
    $display("test custom init done");
    // operating accesses after init
    op_cycle(32'h0000_043C);
    chk8("m_mask_op", m.mask[0], 8'h3C);
    op_cycle(32'h0000_0020);
    chk8("m_op_two", m.op_two[0], 8'h20);
    op_cycle(32'h0000_020B);
    chk8("s2_op_three", m.op_three[2], 8'h0B);
    op_cycle(32'h0000_0C00);
    expect_reg(REG_STAT, 32'h0000_FF00, 32'h0000_3C00);
    $display("test operate done");
    // writes while busy and a bad controller select are dropped
    reg_write(REG_CTRL, 32'h0000_0001);
    reg_write(REG_CFG_M, 32'h0000_FFFF);
    expect_reg(REG_STAT, 32'h0000_0004, 32'h0000_0004);
    wait_idle();
    expect_reg(REG_CFG_M, 32'h0000_FFFF, 32'h0000_C028);
    reg_write(REG_STAT, 32'h0000_0004);
    expect_reg(REG_STAT, 32'h0000_0004, 32'h0000_0000);
    reg_write(REG_OP, 32'h0000_0300);
    expect_reg(REG_STAT, 32'h0000_0004, 32'h0000_0004);
    $display("test refusal done");
    // reset in mid init: host forgets, device keeps its ports
    reg_write(REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    check_defaults();
    chk8("s1_mask_kept", m.mask[1], 8'h5A);
    $display("test reset done");
    give_verdict();
  end
endmodule : cpi_host_tb_top
